// [pcfp_pkg.sv]
// shared constants of the program counter and fetch sequencer
// assumes a single pclk domain and an apb master with 32-bit data
package pcfp_pkg;

	// widths of the counter, its latches and one instruction word, and of their fields
	localparam int unsigned PC_WIDTH = 21;
	localparam int unsigned WORD_WIDTH = 16;
	localparam int unsigned LATCH_WIDTH = 8;
	localparam int unsigned TOP_BITS = PC_WIDTH - 16;
	localparam int unsigned UPPER_BITS = PC_WIDTH - 8;
	localparam int unsigned SECOND_DATA_W = 12;
	localparam int unsigned ABS_HI_W = 8;
	localparam int unsigned REL_OFF_W = 11;

	// one instruction cycle is this many oscillator periods
	localparam int unsigned PHASE_COUNT = 4;

	// byte step between sequential instruction words
	localparam logic [PC_WIDTH-1:0] PC_STEP = 21'h00_0002;

	// top nibble that marks a second word (decodes as no-operation)
	localparam logic [3:0] NOP_NIBBLE = 4'hf;

	// apb byte addresses
	localparam logic [11:0] OFF_PC_LOW = 12'h000;
	localparam logic [11:0] OFF_MID_LATCH = 12'h004;
	localparam logic [11:0] OFF_TOP_LATCH = 12'h008;
	localparam logic [11:0] OFF_STATUS = 12'h00c;

	// reset values
	localparam logic [PC_WIDTH-1:0] RST_PC = 21'h00_0000;
	localparam logic [LATCH_WIDTH-1:0] RST_LATCH = 8'h00;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// status register field positions
	localparam int unsigned STAT_FETCH_VALID = 0;
	localparam int unsigned STAT_EXEC_VALID = 1;
	localparam int unsigned STAT_EXEC_NOP = 2;
	localparam int unsigned STAT_REDIRECT = 3;
	localparam int unsigned STAT_FLUSH = 4;
	localparam int unsigned STAT_STARTED = 5;
	localparam int unsigned STAT_W = 6;

	// phases of the instruction cycle
	typedef enum logic [1:0] {
		PH_ONE,
		PH_TWO,
		PH_THREE,
		PH_FOUR
	} pcfp_phase_e;

endpackage

// [pcfp_phase_gen.sv]
// quarter divider: four non-overlapping phase strobes from pclk
// assumes pclk is the oscillator input and presetn its async reset
`timescale 1ns/100ps
module pcfp_phase_gen (
	input wire logic pclk,
	input wire logic presetn,
	output logic [pcfp_pkg::PHASE_COUNT-1:0] phase_onehot
);

	// whole state of the divider
	typedef struct packed {
		pcfp_pkg::pcfp_phase_e ph;
		logic [pcfp_pkg::PHASE_COUNT-1:0] onehot;
	} pcfp_phg_s;

	pcfp_phg_s s_r;
	pcfp_phg_s s_nxt;

	// step round the four phases, one per oscillator period
	always_comb begin
		s_nxt = s_r;
		case (s_r.ph)
			pcfp_pkg::PH_ONE: begin
				s_nxt.ph = pcfp_pkg::PH_TWO;
				s_nxt.onehot = 4'h2;
			end
			pcfp_pkg::PH_TWO: begin
				s_nxt.ph = pcfp_pkg::PH_THREE;
				s_nxt.onehot = 4'h4;
			end
			pcfp_pkg::PH_THREE: begin
				s_nxt.ph = pcfp_pkg::PH_FOUR;
				s_nxt.onehot = 4'h8;
			end
			default: begin
				// phase four wraps to a new instruction cycle
				s_nxt.ph = pcfp_pkg::PH_ONE;
				s_nxt.onehot = 4'h1;
			end
		endcase
	end

	// reset enters phase one so the first cycle starts clean
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r.ph <= pcfp_pkg::PH_ONE;
			s_r.onehot <= 4'h1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// one-hot straight from the flop, so never two phases at once
	assign phase_onehot = s_r.onehot;

endmodule

// [pcfp_apb_regs.sv]
// apb slave front end: decode, read mux and access pulses
// assumes an apb master on pclk; latch storage lives in the top
`timescale 1ns/100ps
module pcfp_apb_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [pcfp_pkg::PC_WIDTH-1:0] pc_in,
	input wire logic [pcfp_pkg::LATCH_WIDTH-1:0] mid_in,
	input wire logic [pcfp_pkg::LATCH_WIDTH-1:0] top_in,
	input wire logic [pcfp_pkg::STAT_W-1:0] status_in,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic wr_low,
	output logic wr_mid,
	output logic wr_top,
	output logic rd_low,
	output logic [pcfp_pkg::LATCH_WIDTH-1:0] wr_byte,
	output logic [pcfp_pkg::UPPER_BITS-1:0] snap_upper
);

	// whole state of the slave
	typedef struct packed {
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [pcfp_pkg::UPPER_BITS-1:0] snap;
	} pcfp_apb_s;

	pcfp_apb_s s_r;
	pcfp_apb_s s_nxt;
	logic setup;
	logic access;

	// setup cycle and the completing access edge
	assign setup = psel & ~penable;
	assign access = psel & penable & s_r.ready;

	// answer prepared in setup, so every access takes one wait-free cycle
	always_comb begin
		s_nxt = s_r;
		s_nxt.ready = 1'b0;
		// error stands only with ready, never lingers after access
		s_nxt.err = 1'b0;
		if (setup) begin
			s_nxt.ready = 1'b1;
			s_nxt.err = 1'b0;
			s_nxt.rdata = pcfp_pkg::RST_RDATA;
			case (paddr)
				pcfp_pkg::OFF_PC_LOW: begin
					// bit zero of the counter is always zero here
					s_nxt.rdata[7:0] = pc_in[7:0];
					// snapshot keeps latch copy consistent with data
					s_nxt.snap = pc_in[pcfp_pkg::PC_WIDTH-1:8];
				end
				pcfp_pkg::OFF_MID_LATCH: begin
					s_nxt.rdata[7:0] = mid_in;
				end
				pcfp_pkg::OFF_TOP_LATCH: begin
					s_nxt.rdata[7:0] = top_in;
				end
				pcfp_pkg::OFF_STATUS: begin
					s_nxt.rdata[pcfp_pkg::STAT_W-1:0] = status_in;
					// status is read-only
					s_nxt.err = pwrite;
				end
				default: begin
					// unmapped or misaligned address
					s_nxt.err = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r.rdata <= pcfp_pkg::RST_RDATA;
			s_r.ready <= 1'b0;
			s_r.err <= 1'b0;
			s_r.snap <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// access pulses, taken only on the completing edge
	assign wr_low = access & pwrite & ~s_r.err
		& (paddr == pcfp_pkg::OFF_PC_LOW);
	assign wr_mid = access & pwrite & ~s_r.err
		& (paddr == pcfp_pkg::OFF_MID_LATCH);
	assign wr_top = access & pwrite & ~s_r.err
		& (paddr == pcfp_pkg::OFF_TOP_LATCH);
	assign rd_low = access & ~pwrite & ~s_r.err
		& (paddr == pcfp_pkg::OFF_PC_LOW);
	assign wr_byte = pwdata[7:0];
	assign snap_upper = s_r.snap;
	assign prdata = s_r.rdata;
	assign pready = s_r.ready;
	assign pslverr = s_r.err;

endmodule

// [pcfp_top.sv]
// program counter, latch registers and two-stage fetch pipeline
// assumes program memory and core decode logic run on pclk;
// memory presents the word for pmem_addr by the end of phase four
// Contract
// - counter is 21 bits, byte addressed
// - low counter byte is read/write
// - middle byte changes only via middle latch
// - top bits change only via top latch
// - low byte write loads both latches in
// - low byte read copies upper bytes out
// - bit zero stays zero, step two
// - jumps and branches bypass the latches
// - pclk divided into four phases
// - counter steps phase one, fetch latched phase four
// - fetch overlaps execute, one cycle each
// - counter change flushes fetched word, two cycles
// - latch phase one, read two, write four
// - words of two bytes, even aligned
// - absolute jump word address to bits 20:1
// - relative offset counts words, doubled
// - second word top nibble ones, nop, 12 bits
// - skipped-into second word runs as nop
// - calls push, returns restore the counter
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module pcfp_top #(
	parameter int unsigned OFF_W = pcfp_pkg::REL_OFF_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [pcfp_pkg::PC_WIDTH-1:0] pmem_addr,
	output logic pmem_rd,
	input wire logic [pcfp_pkg::WORD_WIDTH-1:0] pmem_rdata,
	input wire logic ctl_abs_jump,
	input wire logic [pcfp_pkg::ABS_HI_W-1:0] ctl_abs_hi,
	input wire logic ctl_rel_jump,
	input wire logic [OFF_W-1:0] ctl_rel_offset,
	input wire logic ctl_push,
	input wire logic ctl_return,
	input wire logic [pcfp_pkg::PC_WIDTH-1:0] ctl_return_addr,
	input wire logic ctl_skip,
	output logic [pcfp_pkg::PHASE_COUNT-1:0] phase_onehot,
	output logic [pcfp_pkg::WORD_WIDTH-1:0] instruction_latch,
	output logic exec_valid,
	output logic exec_nop,
	output logic [pcfp_pkg::SECOND_DATA_W-1:0] second_word_data,
	output logic operand_read,
	output logic dest_write,
	output logic ret_push,
	output logic [pcfp_pkg::PC_WIDTH-1:0] ret_push_addr
);

	localparam int unsigned PCW = pcfp_pkg::PC_WIDTH;
	localparam int unsigned WW = pcfp_pkg::WORD_WIDTH;
	localparam int unsigned LW = pcfp_pkg::LATCH_WIDTH;

	// offset must fit under the counter with its doubling bit
	generate
		if (OFF_W < 2 || OFF_W > PCW - 2) begin : g_bad_off
			$error("pcfp_top: OFF_W out of range");
		end
	endgenerate

	// whole state of the sequencer
	typedef struct packed {
		logic [PCW-1:0] pc;
		logic [LW-1:0] mid;
		logic [LW-1:0] top;
		logic [WW-1:0] fetch_word;
		logic fetch_valid;
		logic [WW-1:0] ilatch;
		logic exec_valid;
		logic exec_nop;
		logic redirect;
		logic [PCW-1:0] target;
		logic flush;
		logic started;
		logic opr_rd;
		logic dst_wr;
		logic mem_rd;
		logic push;
		logic [PCW-1:0] push_addr;
	} pcfp_top_s;

	pcfp_top_s s_r;
	pcfp_top_s s_nxt;

	// phase strobes and register access pulses
	logic [pcfp_pkg::PHASE_COUNT-1:0] ph;
	logic wr_low;
	logic wr_mid;
	logic wr_top;
	logic rd_low;
	logic [LW-1:0] wr_byte;
	logic [pcfp_pkg::UPPER_BITS-1:0] snap_upper;
	logic [pcfp_pkg::STAT_W-1:0] status;
	// doubled, sign-extended branch displacement
	logic [PCW-1:0] rel_disp;
	// instruction in execute actually does work
	logic exec_live;

	pcfp_phase_gen u_phase (
		.pclk(pclk),
		.presetn(presetn),
		.phase_onehot(ph)
	);

	pcfp_apb_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pc_in(s_r.pc),
		.mid_in(s_r.mid),
		.top_in(s_r.top),
		.status_in(status),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.wr_low(wr_low),
		.wr_mid(wr_mid),
		.wr_top(wr_top),
		.rd_low(rd_low),
		.wr_byte(wr_byte),
		.snap_upper(snap_upper)
	);

	// status view of the pipeline for software
	always_comb begin
		status = '0;
		status[pcfp_pkg::STAT_FETCH_VALID] = s_r.fetch_valid;
		status[pcfp_pkg::STAT_EXEC_VALID] = s_r.exec_valid;
		status[pcfp_pkg::STAT_EXEC_NOP] = s_r.exec_nop;
		status[pcfp_pkg::STAT_REDIRECT] = s_r.redirect;
		status[pcfp_pkg::STAT_FLUSH] = s_r.flush;
		status[pcfp_pkg::STAT_STARTED] = s_r.started;
	end

	// offset counts words, so shift up one
	assign rel_disp = {{(PCW - OFF_W - 1){ctl_rel_offset[OFF_W-1]}},
		ctl_rel_offset, 1'b0};
	assign exec_live = s_r.exec_valid & ~s_r.exec_nop;

	// next state; each phase block acts on the edge ending that phase
	always_comb begin
		s_nxt = s_r;
		s_nxt.opr_rd = 1'b0;
		s_nxt.dst_wr = 1'b0;
		s_nxt.mem_rd = 1'b0;
		s_nxt.push = 1'b0;

		// end of phase one: step counter, move fetch into execute
		if (ph[0]) begin
			if (s_r.redirect) begin
				// jump target straight in, latches unused
				s_nxt.pc = s_r.target;
			end else if (s_r.started) begin
				// step by two, bit zero never set
				s_nxt.pc = s_r.pc + pcfp_pkg::PC_STEP;
			end
			// first cycle after reset fetches address zero itself
			s_nxt.started = 1'b1;
			s_nxt.redirect = 1'b0;
			s_nxt.flush = 1'b0;
			// instruction latch loads in phase one
			// execute the word fetched last cycle
			s_nxt.ilatch = s_r.fetch_word;
			// a redirect or skip discards the fetched word
			s_nxt.exec_valid = s_r.fetch_valid & ~s_r.flush
				& ~s_r.redirect;
			// a lone second word runs as nop
			s_nxt.exec_nop = (s_r.fetch_word[WW-1:WW-4]
				== pcfp_pkg::NOP_NIBBLE);
			s_nxt.fetch_valid = 1'b0;
			// operand read strobe in phase two
			s_nxt.opr_rd = s_nxt.exec_valid & ~s_nxt.exec_nop;
		end

		// end of phase two: read strobe to memory for phase three
		if (ph[1]) begin
			// address is always an even byte
			s_nxt.mem_rd = 1'b1;
		end

		// end of phase three: destination write in phase four
		if (ph[2]) begin
			s_nxt.dst_wr = exec_live;
		end

		// end of phase four: latch fetch, take decode decisions
		if (ph[3]) begin
			// fetched word latched in phase four
			s_nxt.fetch_word = pmem_rdata;
			s_nxt.fetch_valid = 1'b1;
			if (exec_live) begin
				if (ctl_return) begin
					s_nxt.redirect = 1'b1;
					s_nxt.target = {ctl_return_addr[PCW-1:1], 1'b0};
				end else if (ctl_abs_jump) begin
					// low 12 bits come from the second word
					s_nxt.redirect = 1'b1;
					s_nxt.target = {ctl_abs_hi,
						pmem_rdata[pcfp_pkg::SECOND_DATA_W-1:0], 1'b0};
				end else if (ctl_rel_jump) begin
					s_nxt.redirect = 1'b1;
					s_nxt.target = s_r.pc + rel_disp;
				end else if (ctl_skip) begin
					s_nxt.flush = 1'b1;
				end
				if (ctl_push) begin
					// push the address after the call
					s_nxt.push = 1'b1;
					s_nxt.push_addr = ctl_abs_jump
						? s_r.pc + pcfp_pkg::PC_STEP : s_r.pc;
				end
			end
		end

		// software side; a low byte write beats a core redirect taken on the same edge
		if (wr_low) begin
			// latches go into the upper counter bits
			// low byte written, bit zero forced low
			s_nxt.redirect = 1'b1;
			s_nxt.target = {s_r.top[pcfp_pkg::TOP_BITS-1:0], s_r.mid,
				wr_byte[LW-1:1], 1'b0};
		end
		if (wr_mid) begin
			// middle byte reached only through this latch
			s_nxt.mid = wr_byte;
		end
		if (wr_top) begin
			// top bits reached only through this latch
			s_nxt.top = wr_byte;
		end
		if (rd_low) begin
			// upper counter bytes copied into the latches
			s_nxt.mid = snap_upper[LW-1:0];
			s_nxt.top = {{(2 * LW - pcfp_pkg::UPPER_BITS){1'b0}},
				snap_upper[pcfp_pkg::UPPER_BITS-1:LW]};
		end
	end

	// reset clears counter, latches and pipeline
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r.pc <= pcfp_pkg::RST_PC;
			s_r.mid <= pcfp_pkg::RST_LATCH;
			s_r.top <= pcfp_pkg::RST_LATCH;
			s_r.fetch_word <= '0;
			s_r.fetch_valid <= 1'b0;
			s_r.ilatch <= '0;
			s_r.exec_valid <= 1'b0;
			s_r.exec_nop <= 1'b0;
			s_r.redirect <= 1'b0;
			s_r.target <= pcfp_pkg::RST_PC;
			s_r.flush <= 1'b0;
			s_r.started <= 1'b0;
			s_r.opr_rd <= 1'b0;
			s_r.dst_wr <= 1'b0;
			s_r.mem_rd <= 1'b0;
			s_r.push <= 1'b0;
			s_r.push_addr <= pcfp_pkg::RST_PC;
		end else begin
			s_r <= s_nxt;
		end
	end

	// every output below is a flop of the state, except phase_onehot, a flop of the phase divider
	assign pmem_addr = s_r.pc;
	assign pmem_rd = s_r.mem_rd;
	assign phase_onehot = ph;
	assign instruction_latch = s_r.ilatch;
	assign exec_valid = s_r.exec_valid;
	assign exec_nop = s_r.exec_nop;
	assign second_word_data = s_r.fetch_word[pcfp_pkg::SECOND_DATA_W-1:0];
	assign operand_read = s_r.opr_rd;
	assign dest_write = s_r.dst_wr;
	assign ret_push = s_r.push;
	assign ret_push_addr = s_r.push_addr;

endmodule

// [pcfp_top_checker.sv]
// port-level checker for the counter and fetch sequencer
// assumes one pclk domain with async active-low presetn
`timescale 1ns/100ps
module pcfp_top_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [20:0] pmem_addr,
	input wire logic pmem_rd,
	input wire logic [3:0] phase_onehot,
	input wire logic [15:0] instruction_latch,
	input wire logic exec_valid,
	input wire logic exec_nop,
	input wire logic operand_read,
	input wire logic dest_write
);
	// one domain, so one clocking and reset for all
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_PHASE_ROT: assert property (1'b1 |=> phase_onehot ==
		{$past(phase_onehot[2:0]), $past(phase_onehot[3])})
		else $error("phase strobe did not rotate");
	AST_PC_EVEN: assert property (pmem_addr[0] == 1'b0)
		else $error("counter bit zero set");
	// counter may only move at the edge ending phase one
	AST_PC_HOLD: assert property (!phase_onehot[0] |=> $stable(pmem_addr))
		else $error("counter moved outside phase one");
	AST_FETCH_PH3: assert property (pmem_rd |-> phase_onehot[2])
		else $error("memory read outside phase three");
	AST_EXEC_HOLD: assert property (!phase_onehot[0] |=>
		$stable(instruction_latch) && $stable(exec_valid))
		else $error("execute word changed mid cycle");
	AST_NOP_DEC: assert property (exec_valid |->
		exec_nop == (instruction_latch[15:12] == 4'hf))
		else $error("second word decode wrong");
	AST_OPRD: assert property (operand_read |->
		phase_onehot[1] && exec_valid ##2 dest_write)
		else $error("operand read timing wrong");
	AST_DEST: assert property (dest_write |-> phase_onehot[3] && exec_valid)
		else $error("destination write outside phase four");
	AST_APB_ONE: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("access cycle not exactly one");
	AST_ERR_RDY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_RD_UPPER: assert property (pready && !pwrite |->
		prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
endmodule

bind pcfp_top pcfp_top_checker u_pcfp_top_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
	.phase_onehot(phase_onehot), .instruction_latch(instruction_latch),
	.exec_valid(exec_valid), .exec_nop(exec_nop),
	.operand_read(operand_read), .dest_write(dest_write)
);

// [pcfp_pmem_model.sv]
// behavioural program memory, 256 words, filled by the bench
// assumes pmem_rd marks phase three; word shown during phase four
`timescale 1ns/100ps
module pcfp_pmem_model (
	input wire logic pclk,
	input wire logic [20:0] pmem_addr,
	input wire logic pmem_rd,
	output logic [15:0] pmem_rdata
);
	logic [15:0] mem [256]; // word array, byte address bits 8:1
	logic [20:0] addr_q = 21'h00_0000; // captured fetch address
	logic live = 1'b0; // word valid this cycle only
	always @(posedge pclk) begin
		live <= pmem_rd;
		if (pmem_rd) begin
			addr_q <= pmem_addr;
		end
	end
	// outside the valid cycle show inverted data, not a held word
	assign pmem_rdata = live ? mem[addr_q[8:1]] : ~mem[addr_q[8:1]];
endmodule

// [pcfp_top_tb.sv]
// self-checking bench: apb tasks plus core control strobes
// assumes pcfp_top, its checker and the memory model compiled first
`timescale 1ns/100ps
module pcfp_top_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, pmem_rd, exec_valid, exec_nop;
	logic [20:0] pmem_addr, prev;
	logic [15:0] pmem_rdata, instruction_latch;
	logic ctl_abs_jump = 1'b0;
	logic [7:0] ctl_abs_hi = 8'h00;
	logic ctl_rel_jump = 1'b0;
	logic [10:0] ctl_rel_offset = 11'h000;
	logic [3:0] phase_onehot;
	logic ctl_push = 1'b0;
	logic ctl_return = 1'b0;
	logic ctl_skip = 1'b0;
	logic [20:0] ctl_return_addr = 21'h00_0000;
	logic ret_push;
	logic [20:0] ret_push_addr;
	logic [31:0] rv; // last read data
	logic er; // last error flag
	int fails = 0;
	int tests_run = 0;

	always #4 pclk = ~pclk; // 125 MHz

	pcfp_top #(.OFF_W(11)) u_pcfp_top (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
		.pmem_rdata(pmem_rdata), .ctl_abs_jump(ctl_abs_jump),
		.ctl_abs_hi(ctl_abs_hi), .ctl_rel_jump(ctl_rel_jump),
		.ctl_rel_offset(ctl_rel_offset), .ctl_push(ctl_push),
		.ctl_return(ctl_return), .ctl_return_addr(ctl_return_addr),
		.ctl_skip(ctl_skip),
		.phase_onehot(phase_onehot), .instruction_latch(instruction_latch),
		.exec_valid(exec_valid), .exec_nop(exec_nop),
		.second_word_data(), .operand_read(), .dest_write(),
		.ret_push(ret_push), .ret_push_addr(ret_push_addr));
	pcfp_pmem_model u_pcfp_pmem_model (.pclk(pclk), .pmem_addr(pmem_addr),
		.pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata));

	// word image: every sixteenth word is a second-word pattern
	function automatic logic [15:0] mw(input logic [7:0] i);
		return (i[3:0] == 4'hf) ? {8'hf0, i} : {8'h10, i};
	endfunction

	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// one apb transfer; holds the request until pready is sampled
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a slave that never answers counts as a mismatch
		if (pready !== 1'b1) begin
			fails++;
		end
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// park mid-cycle in phase k+1 so outputs are settled
	task ph(input int k);
		do @(negedge pclk); while (phase_onehot[k] !== 1'b1);
	endtask

	// issue one jump from a live phase-four decision edge
	task jump(input logic rel, input logic [10:0] off);
		logic [20:0] a, t;
		do ph(2); while (exec_valid !== 1'b1 || exec_nop !== 1'b0);
		a = pmem_addr;
		t = rel ? a + {{9{off[10]}}, off, 1'b0} : {8'h05, 4'h0, a[8:1], 1'b0};
		@(posedge pclk);
		ctl_abs_jump <= !rel;
		ctl_rel_jump <= rel;
		ctl_abs_hi <= 8'h05;
		ctl_rel_offset <= off;
		@(posedge pclk);
		ctl_abs_jump <= 1'b0;
		ctl_rel_jump <= 1'b0;
		ph(1);
		chk(pmem_addr, t);
		chk(exec_valid, 0);
		ph(1);
		chk(instruction_latch, mw(t[8:1]));
	endtask

	// return with push, or skip, from a live phase-four edge
	task misc(input logic sk);
		logic [20:0] a;
		do ph(2); while (exec_valid !== 1'b1 || exec_nop !== 1'b0);
		a = pmem_addr;
		@(posedge pclk);
		ctl_return <= !sk;
		ctl_push <= !sk;
		ctl_skip <= sk;
		ctl_return_addr <= 21'h00_0123;
		@(posedge pclk);
		ctl_return <= 1'b0;
		ctl_push <= 1'b0;
		ctl_skip <= 1'b0;
		@(negedge pclk);
		chk(ret_push, !sk);
		if (!sk) begin
			chk(ret_push_addr, a);
		end
		ph(1);
		chk(pmem_addr, sk ? a + 21'h00_0002 : 21'h00_0122);
		chk(exec_valid, 0);
	endtask

	task results();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		for (int i = 0; i < 256; i++) begin
			u_pcfp_pmem_model.mem[i] = mw(8'(i));
		end
		@(negedge pclk);
		chk(phase_onehot, 4'h1);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		ph(1);
		chk(pmem_addr, 0);
		prev = pmem_addr;
		for (int i = 0; i < 20; i++) begin
			ph(1);
			chk(pmem_addr, prev + 21'h2);
			prev = pmem_addr;
			chk(instruction_latch, mw(pmem_addr[8:1] - 8'h1));
			chk(exec_nop, pmem_addr[4:1] == 4'h0);
		end
		$display("sequential fetch test done");
		apb(1'b0, 12'h004, 0);
		chk(rv, 0);
		apb(1'b0, 12'h008, 0);
		chk(rv, 0);
		apb(1'b1, 12'h004, 32'h0000_0012);
		apb(1'b1, 12'h008, 32'h0000_003f);
		apb(1'b0, 12'h008, 0);
		chk(rv, 32'h0000_003f);
		apb(1'b1, 12'h000, 32'h0000_0041);
		repeat (8) @(posedge pclk);
		chk(pmem_addr[20:6], 15'h7c49);
		apb(1'b1, 12'h004, 0);
		apb(1'b1, 12'h008, 0);
		chk(pmem_addr[20:8], 13'h1f12);
		apb(1'b0, 12'h000, 0);
		chk(rv[0], 0);
		apb(1'b0, 12'h004, 0);
		chk(rv, 32'h0000_0012);
		apb(1'b0, 12'h008, 0);
		chk(rv, 32'h0000_001f);
		apb(1'b0, 12'h010, 0);
		chk(er, 1);
		apb(1'b1, 12'h00c, 0);
		chk(er, 1);
		$display("register test done");
		jump(1'b0, 11'h000);
		jump(1'b1, 11'h7fd);
		jump(1'b1, 11'h005);
		misc(1'b0);
		misc(1'b1);
		$display("jump test done");
		results();
	end

	// hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		results();
	end
endmodule
